//--- core/tpc_capture.v
`timescale 1ns/1ps
`include "tpc_consts.vh"
// What this block does
// - A started capture waits for its trigger, stores the pattern, then stops and drops its active flag.
// - A start is refused while burst sequencing or quick sync is set.
// - A start is refused while the error measurement reports sync loss.
// - A start is refused while another data interface is capturing.
// - Memory of 8 Mbit splits into 1 to 128 blocks, each 8 Mbit over the count.
// - Error trigger starts capture on a detected bit error.
// - Pattern trigger fires when all unmasked bits equal the match pattern.
// - Match length is 4 to 64 bits in 4-bit steps, used only by pattern trigger.
// - A mask bit of 1 leaves that bit out, a 0 demands an exact match.
// - With paired channels a pattern off nibble boundaries never triggers.
// - The software trigger counts only when the manual source is chosen.
// - Each manual trigger captures one block; software triggers once per block.
// - External trigger fires on a falling edge of the trigger input.
// - Trigger position puts the trigger at window start, centre or end.
// - Read-out covers all blocks or a start and count, and the captured count is shown.
// - Abort stops read-out and leaves finished blocks valid.
module tpc_capture (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // received stream and measurement state
    input wire rx_valid,
    input wire rx_bit,
    input wire rx_err,
    input wire sync_loss,
    input wire other_if_busy,
    input wire ext_trig_n,
    // capture state
    output wire capture_active,
    // read-out stream
    output reg rd_valid,
    input wire rd_ready,
    output reg rd_data,
    output reg rd_err,
    output reg [6:0] rd_block,
    output reg rd_last,
    // interrupt
    output wire irq
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ARM = 3'b010;
    localparam [2:0] ST_POST = 3'b100;

    reg [2:0] state_reg;
    reg [31:0] cfg_reg;
    reg [63:0] pat_reg;
    reg [63:0] mask_reg;
    reg [7:0] rd_first_reg;
    reg [7:0] rd_count_reg;
    reg [`TPC_IRQ_W-1:0] irq_stat_reg;
    reg [`TPC_IRQ_W-1:0] irq_mask_reg;
    reg [7:0] cur_blk_reg;
    reg [7:0] captured_reg;
    reg [`TPC_AW-1:0] wptr_reg;
    reg [23:0] post_reg;
    reg ext_prev_reg;
    reg rd_busy_reg;
    reg [7:0] r_blk_reg;
    reg [7:0] r_end_reg;
    reg [`TPC_AW-1:0] r_idx_reg;
    reg [7:0] blocks_read_reg;

    // data and error flag per bit, and oldest-bit offset per block
    reg [1:0] cap_mem [0:`TPC_MEM_LAST];
    reg [`TPC_AW-1:0] blk_start [0:`TPC_MAX_BLK-1];

    function [`TPC_AW-1:0] blk_base;
        input [6:0] blk;
        input [2:0] code;
        reg [29:0] t;
        begin
            t = {blk, 23'h0} >> code;
            blk_base = t[`TPC_AW-1:0];
        end
    endfunction

    // block geometry
    wire [2:0] nblk_code = cfg_reg[`TPC_CFG_NBLK_HI:`TPC_CFG_NBLK_LO];
    wire [23:0] blk_len = `TPC_MEM_BITS >> nblk_code;
    wire [`TPC_AW-1:0] len_mask = blk_len[`TPC_AW-1:0] - 23'h1;
    wire [7:0] nblk = 8'h01 << nblk_code;
    wire [1:0] src = cfg_reg[`TPC_CFG_SRC_HI:`TPC_CFG_SRC_LO];
    wire [1:0] pos = cfg_reg[`TPC_CFG_POS_HI:`TPC_CFG_POS_LO];

    // apb decode
    wire apb_wr = psel & penable & pwrite;
    wire apb_setup = psel & ~penable;
    reg addr_ok;
    reg [31:0] rd_mux;
    wire [31:0] status_word;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    always @* begin
        addr_ok = 1'b1;
        rd_mux = 32'h00000000;
        if (paddr == `TPC_OFF_CTRL) begin
            rd_mux = 32'h00000000;
        end else if (paddr == `TPC_OFF_CONFIG) begin
            rd_mux = cfg_reg;
        end else if (paddr == `TPC_OFF_PAT_LO) begin
            rd_mux = pat_reg[31:0];
        end else if (paddr == `TPC_OFF_PAT_HI) begin
            rd_mux = pat_reg[63:32];
        end else if (paddr == `TPC_OFF_MASK_LO) begin
            rd_mux = mask_reg[31:0];
        end else if (paddr == `TPC_OFF_MASK_HI) begin
            rd_mux = mask_reg[63:32];
        end else if (paddr == `TPC_OFF_RANGE) begin
            rd_mux = {16'h0000, rd_count_reg, rd_first_reg};
        end else if (paddr == `TPC_OFF_STATUS) begin
            rd_mux = status_word;
        end else if (paddr == `TPC_OFF_IRQ_STAT) begin
            rd_mux = {28'h0000000, irq_stat_reg};
        end else if (paddr == `TPC_OFF_IRQ_MASK) begin
            rd_mux = {28'h0000000, irq_mask_reg};
        end else begin
            addr_ok = 1'b0;
        end
    end

    wire ctrl_wr = apb_wr & addr_ok & (paddr == `TPC_OFF_CTRL);
    wire cmd_start = ctrl_wr & pwdata[`TPC_CTRL_START];
    wire cmd_stop = ctrl_wr & pwdata[`TPC_CTRL_STOP];
    wire cmd_trig = ctrl_wr & pwdata[`TPC_CTRL_TRIG];
    wire cmd_rdgo = ctrl_wr & pwdata[`TPC_CTRL_RDGO];
    wire cmd_abort = ctrl_wr & pwdata[`TPC_CTRL_ABORT];

    // start refusal conditions
    wire start_block = cfg_reg[`TPC_CFG_BURST] | cfg_reg[`TPC_CFG_QUICK]
        | sync_loss
        | other_if_busy
        | (state_reg != ST_IDLE);
    wire start_ok = cmd_start & ~start_block;
    wire start_rej = cmd_start & start_block;

    // trigger sources
    wire ext_lvl;
    wire match_hit;

    tpc_sync #(
        .RST_VAL(1'b1)
    ) u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_trig_n),
        .level(ext_lvl)
    );

    tpc_match u_match (
        .pclk(pclk),
        .presetn(presetn),
        .bit_valid(rx_valid),
        .bit_in(rx_bit),
        .pattern(pat_reg),
        .mask(mask_reg),
        .len_code(cfg_reg[`TPC_CFG_LEN_HI:`TPC_CFG_LEN_LO]),
        .pairing(cfg_reg[`TPC_CFG_PAIR]),
        .hit(match_hit)
    );

    wire ext_fall = ext_prev_reg & ~ext_lvl;
    reg trig;
    always @* begin
        case (src)
            `TPC_SRC_ERR: trig = rx_valid & rx_err;
            `TPC_SRC_MATCH: trig = match_hit;
            `TPC_SRC_MAN: trig = cmd_trig;
            default: trig = ext_fall;
        endcase
    end

    // bits still to store after the trigger
    reg [23:0] post_len;
    always @* begin
        if (pos == `TPC_POS_MID) begin
            post_len = blk_len >> 1;
        end else if (pos == `TPC_POS_BOT) begin
            post_len = 24'h000000;
        end else begin
            post_len = blk_len - 24'h000001;
        end
    end

    wire storing = (state_reg != ST_IDLE) & rx_valid;
    wire [`TPC_AW-1:0] wptr_inc = (wptr_reg + 23'h1) & len_mask;
    wire [`TPC_AW-1:0] wptr_nxt = storing ? wptr_inc : wptr_reg;
    wire [`TPC_AW-1:0] wr_addr = blk_base(cur_blk_reg[6:0], nblk_code)
        + wptr_reg;
    wire arm_trig = (state_reg == ST_ARM) & trig;
    wire blk_fin = (arm_trig & (post_len == 24'h000000)) |
        ((state_reg == ST_POST) & rx_valid & (post_reg == 24'h000001));
    wire last_blk = (cur_blk_reg + 8'h01) == nblk;
    wire cap_done = blk_fin & last_blk;

    // memory write port: window is circular until the block closes
    always @(posedge pclk) begin
        if (storing) begin
            cap_mem[wr_addr] <= {rx_err, rx_bit};
        end
        if (blk_fin) begin
            blk_start[cur_blk_reg[6:0]] <= wptr_nxt;
        end
    end

    // capture sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cur_blk_reg <= 8'h00;
            captured_reg <= 8'h00;
            wptr_reg <= {`TPC_AW{1'b0}};
            post_reg <= 24'h000000;
            ext_prev_reg <= 1'b1;
        end else begin
            ext_prev_reg <= ext_lvl;
            wptr_reg <= wptr_nxt;
            case (state_reg)
                ST_IDLE: begin
                    if (start_ok) begin
                        state_reg <= ST_ARM;
                        cur_blk_reg <= 8'h00;
                        captured_reg <= 8'h00;
                        wptr_reg <= {`TPC_AW{1'b0}};
                    end
                end
                ST_ARM: begin
                    if (cmd_stop) begin
                        state_reg <= ST_IDLE;
                    end else if (arm_trig & ~blk_fin) begin
                        state_reg <= ST_POST;
                        post_reg <= post_len;
                    end
                end
                ST_POST: begin
                    if (cmd_stop) begin
                        state_reg <= ST_IDLE;
                    end else if (rx_valid) begin
                        post_reg <= post_reg - 24'h000001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (blk_fin & ~cmd_stop) begin
                // each block waits for a trigger of its own
                cur_blk_reg <= cur_blk_reg + 8'h01;
                captured_reg <= captured_reg + 8'h01;
                wptr_reg <= {`TPC_AW{1'b0}};
                state_reg <= last_blk ? ST_IDLE : ST_ARM;
            end
        end
    end

    assign capture_active = (state_reg != ST_IDLE);

    // read-out range, clipped to what was captured
    wire rd_all = cfg_reg[`TPC_CFG_RDALL];
    wire [7:0] r_first = rd_all ? 8'h00 : rd_first_reg;
    wire [8:0] r_sum = {1'b0, r_first} + {1'b0, rd_count_reg};
    wire [7:0] r_end = rd_all ? captured_reg :
        ((r_sum > {1'b0, captured_reg}) ? captured_reg : r_sum[7:0]);
    wire rd_start = cmd_rdgo & ~rd_busy_reg & ~rd_valid &
        (state_reg == ST_IDLE);
    wire rd_abort = cmd_abort & (rd_busy_reg | rd_valid);
    wire rd_issue = rd_busy_reg & (~rd_valid | rd_ready) & ~rd_abort;
    wire rd_blk_end = r_idx_reg == len_mask;
    wire rd_fin = rd_issue & rd_blk_end &
        ((r_blk_reg + 8'h01) == r_end_reg);
    wire rd_empty = rd_start & (r_first >= r_end);
    wire [`TPC_AW-1:0] rd_off = (blk_start[r_blk_reg[6:0]] + r_idx_reg)
        & len_mask;
    wire [`TPC_AW-1:0] rd_addr = blk_base(r_blk_reg[6:0], nblk_code)
        + rd_off;

    // read-out engine; a half-sent block is simply not counted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_busy_reg <= 1'b0;
            r_blk_reg <= 8'h00;
            r_end_reg <= 8'h00;
            r_idx_reg <= {`TPC_AW{1'b0}};
            blocks_read_reg <= 8'h00;
            rd_valid <= 1'b0;
            rd_data <= 1'b0;
            rd_err <= 1'b0;
            rd_block <= 7'h00;
            rd_last <= 1'b0;
        end else begin
            if (rd_valid & rd_ready & rd_last & ~rd_abort) begin
                blocks_read_reg <= blocks_read_reg + 8'h01;
            end
            if (rd_start) begin
                rd_busy_reg <= ~rd_empty;
                r_blk_reg <= r_first;
                r_end_reg <= r_end;
                r_idx_reg <= {`TPC_AW{1'b0}};
                blocks_read_reg <= 8'h00;
            end else if (rd_abort) begin
                rd_busy_reg <= 1'b0;
                rd_valid <= 1'b0;
            end else if (rd_issue) begin
                rd_valid <= 1'b1;
                rd_data <= cap_mem[rd_addr][0];
                rd_err <= cap_mem[rd_addr][1];
                rd_block <= r_blk_reg[6:0];
                rd_last <= rd_blk_end;
                if (rd_blk_end) begin
                    r_idx_reg <= {`TPC_AW{1'b0}};
                    r_blk_reg <= r_blk_reg + 8'h01;
                    if (rd_fin) begin
                        rd_busy_reg <= 1'b0;
                    end
                end else begin
                    r_idx_reg <= r_idx_reg + 23'h1;
                end
            end else if (rd_valid & rd_ready) begin
                rd_valid <= 1'b0;
            end
        end
    end

    assign status_word = {8'h00, blocks_read_reg, captured_reg,
        5'h00, rd_busy_reg, (state_reg == ST_ARM), capture_active};

    // interrupts: set beats a same-cycle write-one-to-clear
    wire [`TPC_IRQ_W-1:0] irq_set;
    assign irq_set[`TPC_IRQ_DONE] = cap_done & ~cmd_stop;
    assign irq_set[`TPC_IRQ_REJ] = start_rej;
    assign irq_set[`TPC_IRQ_RDDONE] = rd_fin | rd_empty;
    assign irq_set[`TPC_IRQ_RDABORT] = rd_abort;
    wire irq_clr_wr = apb_wr & (paddr == `TPC_OFF_IRQ_STAT);
    wire [`TPC_IRQ_W-1:0] irq_clr = irq_clr_wr ?
        pwdata[`TPC_IRQ_W-1:0] : {`TPC_IRQ_W{1'b0}};

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // register writes and read data capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= `TPC_CFG_RST;
            pat_reg <= 64'h0000000000000000;
            mask_reg <= 64'h0000000000000000;
            rd_first_reg <= 8'h00;
            rd_count_reg <= 8'h00;
            irq_stat_reg <= {`TPC_IRQ_W{1'b0}};
            irq_mask_reg <= {`TPC_IRQ_W{1'b0}};
            prdata <= 32'h00000000;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            if (apb_setup) begin
                prdata <= rd_mux;
            end
            if (apb_wr) begin
                if (paddr == `TPC_OFF_CONFIG) begin
                    cfg_reg <= {16'h0000, pwdata[15:0]};
                end else if (paddr == `TPC_OFF_PAT_LO) begin
                    pat_reg[31:0] <= pwdata;
                end else if (paddr == `TPC_OFF_PAT_HI) begin
                    pat_reg[63:32] <= pwdata;
                end else if (paddr == `TPC_OFF_MASK_LO) begin
                    mask_reg[31:0] <= pwdata;
                end else if (paddr == `TPC_OFF_MASK_HI) begin
                    mask_reg[63:32] <= pwdata;
                end else if (paddr == `TPC_OFF_RANGE) begin
                    rd_first_reg <= pwdata[7:0];
                    rd_count_reg <= pwdata[15:8];
                end else if (paddr == `TPC_OFF_IRQ_MASK) begin
                    irq_mask_reg <= pwdata[`TPC_IRQ_W-1:0];
                end
            end
        end
    end
endmodule // tpc_capture

//--- core/tpc_consts.vh
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH

// register byte offsets
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_CONFIG 8'h04
`define TPC_OFF_PAT_LO 8'h08
`define TPC_OFF_PAT_HI 8'h0C
`define TPC_OFF_MASK_LO 8'h10
`define TPC_OFF_MASK_HI 8'h14
`define TPC_OFF_RANGE 8'h18
`define TPC_OFF_STATUS 8'h1C
`define TPC_OFF_IRQ_STAT 8'h20
`define TPC_OFF_IRQ_MASK 8'h24

// command bits of the control register
`define TPC_CTRL_START 0
`define TPC_CTRL_STOP 1
`define TPC_CTRL_TRIG 2
`define TPC_CTRL_RDGO 3
`define TPC_CTRL_ABORT 4

// configuration fields
`define TPC_CFG_NBLK_HI 2
`define TPC_CFG_NBLK_LO 0
`define TPC_CFG_SRC_HI 5
`define TPC_CFG_SRC_LO 4
`define TPC_CFG_POS_HI 7
`define TPC_CFG_POS_LO 6
`define TPC_CFG_LEN_HI 11
`define TPC_CFG_LEN_LO 8
`define TPC_CFG_PAIR 12
`define TPC_CFG_BURST 13
`define TPC_CFG_QUICK 14
`define TPC_CFG_RDALL 15
`define TPC_CFG_RST 32'h00000000

// trigger sources and trigger positions
`define TPC_SRC_ERR 2'h0
`define TPC_SRC_MATCH 2'h1
`define TPC_SRC_MAN 2'h2
`define TPC_SRC_EXT 2'h3
`define TPC_POS_TOP 2'h0
`define TPC_POS_MID 2'h1
`define TPC_POS_BOT 2'h2

// interrupt status bits
`define TPC_IRQ_W 4
`define TPC_IRQ_DONE 0
`define TPC_IRQ_REJ 1
`define TPC_IRQ_RDDONE 2
`define TPC_IRQ_RDABORT 3

// capture memory: 8 Mbit, up to 128 blocks
`define TPC_MEM_BITS 24'h800000
`define TPC_MEM_LAST 24'h7FFFFF
`define TPC_AW 23
`define TPC_MAX_BLK 128
`define TPC_PAT_W 64
`define TPC_NIB_LAST 2'h3

`endif

//--- core/tpc_sync.v
`timescale 1ns/1ps
module tpc_sync #(
    parameter RST_VAL = 1'b1
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // asynchronous input and its clean level
    input wire async_in,
    output reg level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // level moves only once two later stages agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            level <= RST_VAL;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level <= s3_reg;
            end
        end
    end
endmodule // tpc_sync

//--- core/tpc_match.v
`timescale 1ns/1ps
`include "tpc_consts.vh"
module tpc_match (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // received stream
    input wire bit_valid,
    input wire bit_in,
    // match settings
    input wire [`TPC_PAT_W-1:0] pattern,
    input wire [`TPC_PAT_W-1:0] mask,
    input wire [3:0] len_code,
    input wire pairing,
    // result
    output wire hit
);
    reg [`TPC_PAT_W-1:0] hist_reg;
    reg [1:0] phase_reg;
    wire [`TPC_PAT_W-1:0] hist_next = {hist_reg[`TPC_PAT_W-2:0], bit_in};
    wire [6:0] len_bits = {1'b0, len_code, 2'h0} + 7'h04;
    wire [`TPC_PAT_W-1:0] ok;

    genvar i;
    generate
        for (i = 0; i < `TPC_PAT_W; i = i + 1) begin : g_bit
            localparam [6:0] IDX = i;
            // beyond length or masked bits always agree
            assign ok[i] = (IDX >= len_bits) | mask[i] |
                ~(hist_next[i] ^ pattern[i]);
        end
    endgenerate

    // paired lanes only match on whole nibbles
    assign hit = bit_valid & (&ok) &
        (~pairing | (phase_reg == `TPC_NIB_LAST));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_reg <= {`TPC_PAT_W{1'b0}};
            phase_reg <= 2'h0;
        end else if (bit_valid) begin
            hist_reg <= hist_next;
            phase_reg <= phase_reg + 2'h1;
        end
    end
endmodule // tpc_match

//--- test/tpc_source_model.sv
`timescale 1ns/1ps
module tpc_source_model (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // received stream towards the detector
    output logic rx_valid,
    output logic rx_bit,
    output logic rx_err,
    // external trigger pin, idle high
    output logic ext_trig_n
);
    logic busy = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_bit = 1'b0;
        rx_err = 1'b0;
        ext_trig_n = 1'b1;
    end
    // idle lines toggle so a stale bit is never read as data
    always @(posedge pclk) begin
        if (!busy && presetn) begin
            rx_bit <= ~rx_bit;
            rx_err <= ~rx_err;
        end
    end
    // oldest bit first; err_at above 7 means no errored bit
    task send(input logic [7:0] b, input int err_at);
        int k;
        busy = 1'b1;
        for (k = 7; k >= 0; k--) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_bit <= b[k];
            rx_err <= (k == err_at);
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        busy = 1'b0;
    endtask
    task ext_fall;
        @(posedge pclk);
        ext_trig_n <= 1'b0;
        repeat (8) @(posedge pclk);
        ext_trig_n <= 1'b1;
    endtask
endmodule // tpc_source_model

//--- test/tpc_capture_checker.sv
`timescale 1ns/1ps
`include "tpc_consts.vh"
module tpc_capture_checker (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // capture side
    input wire sync_loss,
    input wire other_if_busy,
    input wire capture_active,
    // read-out
    input wire rd_valid,
    input wire rd_ready,
    input wire rd_data,
    input wire rd_err,
    input wire [6:0] rd_block,
    input wire rd_last
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire ctrl_wr = acc && pwrite && paddr == `TPC_OFF_CTRL;
    wire bad_addr = paddr > `TPC_OFF_IRQ_MASK || paddr[1:0] != 2'h0;
    sequence s_start;
        ctrl_wr && pwdata[`TPC_CTRL_START] && !capture_active;
    endsequence
    sequence s_abort;
        ctrl_wr && pwdata[`TPC_CTRL_ABORT] && rd_valid;
    endsequence
    sequence s_idle4;
        !capture_active [*4];
    endsequence
    property p_arm;
        $rose(capture_active) |-> $past(ctrl_wr && pwdata[`TPC_CTRL_START]);
    endproperty
    a_arm: assert property (p_arm)
        else $error("capture began without a start write");
    property p_sync_ref;
        s_start ##0 sync_loss |=> s_idle4;
    endproperty
    a_sync_ref: assert property (p_sync_ref)
        else $error("start taken during sync loss");
    property p_busy_ref;
        s_start ##0 other_if_busy |=> s_idle4;
    endproperty
    a_busy_ref: assert property (p_busy_ref)
        else $error("start taken while other interface captures");
    property p_abort;
        s_abort |=> !rd_valid [*2];
    endproperty
    a_abort: assert property (p_abort)
        else $error("read-out kept going after abort");
    property p_hold;
        rd_valid && !rd_ready && !ctrl_wr |=>
            rd_valid && $stable({rd_data, rd_err, rd_block, rd_last});
    endproperty
    a_hold: assert property (p_hold)
        else $error("read-out bit changed before acceptance");
    property p_slverr;
        acc |-> pslverr == bad_addr;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("error response wrong for address");
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("access phase without ready");
    property p_ctrl_zero;
        acc && !pwrite && paddr == `TPC_OFF_CTRL |-> prdata == 32'h0;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("command register read non-zero");
endmodule // tpc_capture_checker
bind tpc_capture tpc_capture_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_loss(sync_loss), .other_if_busy(other_if_busy),
    .capture_active(capture_active), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .rd_err(rd_err),
    .rd_block(rd_block), .rd_last(rd_last));

//--- test/tb_test_pattern_capture_trigger.sv
`timescale 1ns/1ps
`include "tpc_consts.vh"
module tb_test_pattern_capture_trigger;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sync_loss = 1'b0;
    logic other_if_busy = 1'b0;
    logic rd_ready = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, rx_valid, rx_bit, rx_err, ext_trig_n;
    wire capture_active, rd_valid, rd_data, rd_err, rd_last, irq;
    wire [6:0] rd_block;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic e;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic err;
    } tpc_row_t;
    tpc_row_t rows [7] = '{'{8'h04, 32'hFFFF3456, 32'h00003456, 1'b0},
        '{8'h08, 32'hA5A50F0F, 32'hA5A50F0F, 1'b0},
        '{8'h0C, 32'h12345678, 32'h12345678, 1'b0},
        '{8'h10, 32'hFFFF0000, 32'hFFFF0000, 1'b0},
        '{8'h14, 32'h0000FFFF, 32'h0000FFFF, 1'b0},
        '{8'h00, 32'h00000000, 32'h00000000, 1'b0},
        '{8'h28, 32'hDEADBEEF, 32'h00000000, 1'b1}};
    logic [31:0] ref_cfg [4] = '{32'h2000, 32'h4000, 32'h0, 32'h0};

    always #4 pclk = ~pclk;

    tpc_capture u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_err(rx_err),
        .sync_loss(sync_loss), .other_if_busy(other_if_busy),
        .ext_trig_n(ext_trig_n), .capture_active(capture_active),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .rd_err(rd_err), .rd_block(rd_block), .rd_last(rd_last), .irq(irq));
    tpc_source_model u_src (.pclk(pclk), .presetn(presetn),
        .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_err(rx_err),
        .ext_trig_n(ext_trig_n));

    task stop_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // ends on the falling edge so callers see settled outputs
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task wait_act(input logic v);
        int i;
        for (i = 0; i < 64; i++) begin
            @(negedge pclk);
            if (capture_active === v)
                break;
        end
        chk_bit(capture_active, v);
    endtask

    initial begin
        #200000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test;
    end

    initial begin
        int i;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`TPC_OFF_CONFIG, `TPC_CFG_RST);
        rdc(`TPC_OFF_STATUS, 32'h0);
        chk_bit(irq, 1'b0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].x);
            chk_bit(e, rows[i].err);
        end
        // burst, quick, sync loss, busy neighbour; last one masked
        for (i = 0; i < 4; i++) begin
            wr(`TPC_OFF_IRQ_MASK, (i < 3) ? 32'h2 : 32'h0);
            wr(`TPC_OFF_CONFIG, ref_cfg[i]);
            @(posedge pclk);
            sync_loss <= (i == 2);
            other_if_busy <= (i == 3);
            wr(`TPC_OFF_CTRL, 32'h1);
            repeat (3) @(negedge pclk);
            chk_bit(capture_active, 1'b0);
            chk_bit(irq, i < 3);
            rdc(`TPC_OFF_IRQ_STAT, 32'h2);
            wr(`TPC_OFF_IRQ_STAT, 32'h2);
            chk_bit(irq, 1'b0);
        end
        @(posedge pclk);
        other_if_busy <= 1'b0;
        wr(`TPC_OFF_CONFIG, 32'h80);
        wr(`TPC_OFF_CTRL, 32'h1);
        rdc(`TPC_OFF_STATUS, 32'h3);
        wr(`TPC_OFF_CTRL, 32'h4);
        repeat (8) @(negedge pclk);
        chk_bit(capture_active, 1'b1);
        u_src.send(8'h00, 3);
        wait_act(1'b0);
        rdc(`TPC_OFF_STATUS, 32'h100);
        rdc(`TPC_OFF_IRQ_STAT, 32'h1);
        wr(`TPC_OFF_CONFIG, 32'hA1);
        wr(`TPC_OFF_CTRL, 32'h1);
        wr(`TPC_OFF_CTRL, 32'h4);
        rdc(`TPC_OFF_STATUS, 32'h103);
        wr(`TPC_OFF_CTRL, 32'h4);
        wait_act(1'b0);
        rdc(`TPC_OFF_STATUS, 32'h200);
        wr(`TPC_OFF_CONFIG, 32'hB0);
        wr(`TPC_OFF_CTRL, 32'h1);
        chk_bit(capture_active, 1'b1);
        u_src.ext_fall();
        wait_act(1'b0);
        // 8-bit match on 1010 above, low nibble masked off
        wr(`TPC_OFF_CONFIG, 32'h1190);
        wr(`TPC_OFF_PAT_LO, 32'hA5);
        wr(`TPC_OFF_MASK_LO, 32'h0F);
        wr(`TPC_OFF_CTRL, 32'h1);
        u_src.send(8'hB0, 8);
        repeat (4) @(negedge pclk);
        chk_bit(capture_active, 1'b1);
        u_src.send(8'hA0, 8);
        wait_act(1'b0);
        rdc(`TPC_OFF_STATUS, 32'h100);
        wr(`TPC_OFF_IRQ_STAT, 32'hF);
        wr(`TPC_OFF_CONFIG, 32'h8190);
        wr(`TPC_OFF_CTRL, 32'h8);
        for (i = 0; i < 16 && rd_valid !== 1'b1; i++)
            @(negedge pclk);
        chk_bit(rd_valid, 1'b1);
        chk({24'h0, rd_last, rd_block}, 32'h0);
        repeat (3) @(posedge pclk);
        rd_ready <= 1'b1;
        repeat (5) @(posedge pclk);
        rd_ready <= 1'b0;
        wr(`TPC_OFF_CTRL, 32'h10);
        chk_bit(rd_valid, 1'b0);
        rdc(`TPC_OFF_STATUS, 32'h100);
        rdc(`TPC_OFF_IRQ_STAT, 32'h8);
        stop_test;
    end
endmodule // tb_test_pattern_capture_trigger
